// File: shared/e1_liu_bank_pkg.sv
// Purpose: Constants and types for the E1 line interface control/status bank
// Assumes: 40 MHz device clock, 8 channels, 8-bit host port
// Notes:   Offsets are primary-bank byte addresses on the host port

package e1_liu_bank_pkg;

    // ==================================================================
    // Geometry
    localparam int          CHANNELS            = 8;

    // ==================================================================
    // Register offsets
    localparam logic [7:0]  ADDR_LOSS_STATE     = 8'h04;
    localparam logic [7:0]  ADDR_FAULT_STATE    = 8'h05;
    localparam logic [7:0]  ADDR_LOSS_MASK      = 8'h06;
    localparam logic [7:0]  ADDR_FAULT_MASK     = 8'h07;
    localparam logic [7:0]  ADDR_LOSS_FLAGS     = 8'h08;
    localparam logic [7:0]  ADDR_FAULT_FLAGS    = 8'h09;
    localparam logic [7:0]  ADDR_SOFT_RESET     = 8'h0A;
    localparam logic [7:0]  ADDR_MONITOR        = 8'h0B;
    localparam logic [7:0]  ADDR_LOOPBACK       = 8'h0C;
    localparam logic [7:0]  ADDR_CRITERIA       = 8'h0D;
    localparam logic [7:0]  ADDR_AUTO_ONES      = 8'h0E;
    localparam logic [7:0]  ADDR_GLOBAL         = 8'h0F;
    localparam logic [7:0]  ADDR_DRIVER_HIZ     = 8'h12;
    localparam logic [7:0]  ADDR_AIS_STATE      = 8'h13;
    localparam logic [7:0]  ADDR_AIS_MASK       = 8'h14;
    localparam logic [7:0]  ADDR_AIS_FLAGS      = 8'h15;

    // ==================================================================
    // Reset values
    localparam logic [7:0]  RST_CHANNEL_REG     = 8'h00;
    localparam logic [7:0]  RST_SOFT_RESET      = 8'hFF;
    localparam logic [3:0]  RST_MONITOR         = 4'h0;
    localparam logic [6:0]  RST_GLOBAL          = 7'h00;
    localparam logic [7:0]  READ_UNMAPPED       = 8'h00;

    // ==================================================================
    // Field positions
    localparam int          MON_TX_BIT          = 3;
    localparam int          GCF_ALARM_INSERT    = 6;
    localparam int          GCF_SHORT_BYPASS    = 5;
    localparam int          GCF_AMI             = 4;
    localparam int          GCF_FIFO_DEPTH      = 3;
    localparam int          GCF_BANDWIDTH       = 2;
    localparam int          GCF_PATH_MSB        = 1;
    localparam int          GCF_PATH_LSB        = 0;
    localparam logic [1:0]  JITTER_PATH_TX      = 2'h1;
    localparam logic [1:0]  JITTER_PATH_RX      = 2'h3;

    // ==================================================================
    // Timing
    localparam int          CLK_PERIOD_NS       = 25;
    localparam int          SRST_TIME_NS        = 1000;
    localparam int          SRST_CYCLES_INT     = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0]  SRST_CYCLES         = 6'(SRST_CYCLES_INT);

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic [7:0] loss;
        logic [7:0] fault;
        logic [7:0] alarm_indication_state;
    } line_status_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_type;

    typedef struct packed {
        logic [7:0] loopback_en;
        logic [7:0] criteria_etsi;
        logic [7:0] driver_hiz;
        logic [7:0] all_ones_tx;
        logic [7:0] alarm_insert;
    } channel_ctrl_type;

    typedef struct packed {
        logic       monitor_active;
        logic       monitor_tx;
        logic [2:0] monitor_channel;
        logic       short_protect_on;
        logic       ami_select;
        logic       jitter_fifo_deep;
        logic       jitter_bw_high;
        logic       jitter_in_tx;
        logic       jitter_in_rx;
        logic       soft_reset_busy;
    } global_ctrl_type;

    typedef struct packed {
        line_status_type s1;
        line_status_type s2;
        line_status_type s3;
        line_status_type stable;
        logic [7:0]      loss_mask;
        logic [7:0]      fault_mask;
        logic [7:0]      ais_mask;
        logic [7:0]      loss_flags;
        logic [7:0]      fault_flags;
        logic [7:0]      ais_flags;
        logic [3:0]      monitor;
        logic [7:0]      loopback;
        logic [7:0]      criteria;
        logic [7:0]      auto_ones;
        logic [6:0]      global_cfg;
        logic [7:0]      driver_hiz;
        logic [5:0]      srst_count;
        logic [7:0]      all_ones;
        logic [7:0]      alarm_insert;
        logic [7:0]      rdata;
        logic            rvalid;
    } bank_state_type;

    localparam bank_state_type STATE_RESET = '0;

endpackage

// File: verilog/e1_liu_control_status_bank.sv
// Purpose: Per-channel control and status register bank, primary addresses 04H..15H
// Assumes: Host strobes are one-cycle pulses on clk; line status arrives asynchronously
// Notes:   Read data is valid one cycle after the read strobe
//
// Notes on behaviour
// - Masked loss change in either direction sets loss flag; status read clears it.
// - Masked driver-fault change sets fault flag; fault status read clears it.
// - Masked ALARM_INDICATION_STATE change sets ALARM_INDICATION_STATE flag; ALARM_INDICATION_STATE status read clears it.
// - Any write to reset location outside a running reset starts 1 us cycle restoring all defaults.
// - Reset location content stays all ones after a write.
// - Monitor codes 0001..0111 route receivers 1..7 to monitor channel.
// - Monitor codes 1001..1111 route transmitters 1..7 to monitor channel.
// - Codes 0000 and 1000 mean no monitoring; upper monitor bits read zero.
// - Loopback bit set enables digital loopback on that channel; resets zero.
// - Criteria bit selects G.775 when 0, ETSI 300 233 when 1.
// - Auto all-ones bit sends all ones to line during loss of signal.
// - Global alarm-insert bit inserts ALARM_INDICATION_STATE to system side on loss.
// - Protection-bypass bit 0 keeps short-circuit protection, 1 turns it off.
// - Encoding bit 0 selects HDB3, 1 selects AMI.
// - Depth bit 0 selects 32-bit jitter FIFO, 1 selects 64-bit.
// - Bandwidth bit 0 gives 1.7 Hz corner, 1 gives 6.6 Hz.
// - Path 01 puts attenuator in transmit, 11 in receive, else unused.
// - Output-enable bit set puts channel drivers in high impedance.
// - ALARM_INDICATION_STATE status register reads 1 while ALARM_INDICATION_STATE detected on channel.
// - ALARM_INDICATION_STATE mask bit 1 allows the ALARM_INDICATION_STATE interrupt flag, 0 blocks it.
// - Loss mask bit 1 allows the loss flag, 0 blocks it.
// - Fault mask bit 1 allows the driver-fault flag, 0 blocks it.

`timescale 1ns/100ps

module e1_liu_control_status_bank
    import e1_liu_bank_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // Host port
    input  wire host_req_type    host_req,
    output logic [7:0]           host_rdata,
    output logic                 host_rvalid,
    // Line status from the analog front end
    input  wire line_status_type line_status,
    // Controls toward the datapath
    output channel_ctrl_type     channel_ctrl,
    output global_ctrl_type      global_ctrl
);

    // ==================================================================
    // Decoding
    function automatic logic mon_active(input logic [3:0] code);
        mon_active = (code[2:0] != 3'h0);
    endfunction

    function automatic logic [7:0] keep_flags(input logic [7:0] flags, input logic clr,
                                              input logic [7:0] set);
        // Set wins over a clear arriving in the same cycle
        keep_flags = (flags & ~{8{clr}}) | set;
    endfunction

    bank_state_type state_reg;
    bank_state_type state_next;

    logic            busy;
    logic            wr_ok;
    logic            rd_ok;
    line_status_type agree;
    line_status_type changed;
    logic [7:0]      loss_evt;
    logic [7:0]      fault_evt;
    logic [7:0]      ais_evt;

    assign busy = (state_reg.srst_count != 6'h00);
    assign wr_ok = host_req.wr && !busy;
    assign rd_ok = host_req.rd;

    // ==================================================================
    // Input filter: a change counts once the second and third stages agree
    assign agree   = ~(state_reg.s2 ^ state_reg.s3);
    assign changed = agree & (state_reg.s3 ^ state_reg.stable);

    assign loss_evt  = changed.loss  & state_reg.loss_mask;
    assign fault_evt = changed.fault & state_reg.fault_mask;
    assign ais_evt   = changed.alarm_indication_state   & state_reg.ais_mask;

    // ==================================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.s1 = line_status;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.stable = (agree & state_reg.s3) | (~agree & state_reg.stable);

        state_next.loss_flags  = keep_flags(state_reg.loss_flags,
                                            rd_ok && host_req.addr == ADDR_LOSS_STATE, loss_evt);
        state_next.fault_flags = keep_flags(state_reg.fault_flags,
                                            rd_ok && host_req.addr == ADDR_FAULT_STATE, fault_evt);
        state_next.ais_flags   = keep_flags(state_reg.ais_flags,
                                            rd_ok && host_req.addr == ADDR_AIS_STATE, ais_evt);

        if (busy) begin
            state_next.srst_count = state_reg.srst_count - 6'h01;
        end

        if (wr_ok) begin
            unique case (host_req.addr)
                ADDR_LOSS_MASK:   state_next.loss_mask  = host_req.wdata;
                ADDR_FAULT_MASK:  state_next.fault_mask = host_req.wdata;
                ADDR_SOFT_RESET:  state_next.srst_count = SRST_CYCLES;
                ADDR_MONITOR:     state_next.monitor    = host_req.wdata[3:0];
                ADDR_LOOPBACK:    state_next.loopback   = host_req.wdata;
                ADDR_CRITERIA:    state_next.criteria   = host_req.wdata;
                ADDR_AUTO_ONES:   state_next.auto_ones  = host_req.wdata;
                ADDR_GLOBAL:      state_next.global_cfg = host_req.wdata[6:0];
                ADDR_DRIVER_HIZ:  state_next.driver_hiz = host_req.wdata;
                ADDR_AIS_MASK:    state_next.ais_mask   = host_req.wdata;
                default: begin
                end
            endcase
        end

        // Hold every register at its default for the whole reset cycle; events
        // seen meanwhile are dropped, as the flags must read clear afterwards
        if (busy || (wr_ok && host_req.addr == ADDR_SOFT_RESET)) begin
            state_next.loss_mask   = RST_CHANNEL_REG;
            state_next.fault_mask  = RST_CHANNEL_REG;
            state_next.ais_mask    = RST_CHANNEL_REG;
            state_next.loss_flags  = RST_CHANNEL_REG;
            state_next.fault_flags = RST_CHANNEL_REG;
            state_next.ais_flags   = RST_CHANNEL_REG;
            state_next.monitor     = RST_MONITOR;
            state_next.loopback    = RST_CHANNEL_REG;
            state_next.criteria    = RST_CHANNEL_REG;
            state_next.auto_ones   = RST_CHANNEL_REG;
            state_next.global_cfg  = RST_GLOBAL;
            state_next.driver_hiz  = RST_CHANNEL_REG;
        end

        state_next.all_ones     = state_reg.auto_ones & state_reg.stable.loss;
        state_next.alarm_insert = {8{state_reg.global_cfg[GCF_ALARM_INSERT]}}
                                  & state_reg.stable.loss;

        state_next.rvalid = rd_ok;
        unique case (host_req.addr)
            ADDR_LOSS_STATE:  state_next.rdata = state_reg.stable.loss;
            ADDR_FAULT_STATE: state_next.rdata = state_reg.stable.fault;
            ADDR_LOSS_MASK:   state_next.rdata = state_reg.loss_mask;
            ADDR_FAULT_MASK:  state_next.rdata = state_reg.fault_mask;
            ADDR_LOSS_FLAGS:  state_next.rdata = state_reg.loss_flags;
            ADDR_FAULT_FLAGS: state_next.rdata = state_reg.fault_flags;
            ADDR_SOFT_RESET:  state_next.rdata = RST_SOFT_RESET;
            ADDR_MONITOR:     state_next.rdata = {4'h0, state_reg.monitor};
            ADDR_LOOPBACK:    state_next.rdata = state_reg.loopback;
            ADDR_CRITERIA:    state_next.rdata = state_reg.criteria;
            ADDR_AUTO_ONES:   state_next.rdata = state_reg.auto_ones;
            ADDR_GLOBAL:      state_next.rdata = {1'b0, state_reg.global_cfg};
            ADDR_DRIVER_HIZ:  state_next.rdata = state_reg.driver_hiz;
            ADDR_AIS_STATE:   state_next.rdata = state_reg.stable.alarm_indication_state;
            ADDR_AIS_MASK:    state_next.rdata = state_reg.ais_mask;
            ADDR_AIS_FLAGS:   state_next.rdata = state_reg.ais_flags;
            default:          state_next.rdata = READ_UNMAPPED;
        endcase
        if (!rd_ok) begin
            state_next.rdata = state_reg.rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==================================================================
    // Outputs
    assign host_rdata  = state_reg.rdata;
    assign host_rvalid = state_reg.rvalid;

    assign channel_ctrl.loopback_en   = state_reg.loopback;
    assign channel_ctrl.criteria_etsi = state_reg.criteria;
    assign channel_ctrl.driver_hiz    = state_reg.driver_hiz;
    assign channel_ctrl.all_ones_tx   = state_reg.all_ones;
    assign channel_ctrl.alarm_insert  = state_reg.alarm_insert;

    assign global_ctrl.monitor_active   = mon_active(state_reg.monitor);
    assign global_ctrl.monitor_tx       = state_reg.monitor[MON_TX_BIT];
    assign global_ctrl.monitor_channel  = state_reg.monitor[2:0];
    assign global_ctrl.short_protect_on = !state_reg.global_cfg[GCF_SHORT_BYPASS];
    assign global_ctrl.ami_select       = state_reg.global_cfg[GCF_AMI];
    assign global_ctrl.jitter_fifo_deep = state_reg.global_cfg[GCF_FIFO_DEPTH];
    assign global_ctrl.jitter_bw_high   = state_reg.global_cfg[GCF_BANDWIDTH];
    assign global_ctrl.jitter_in_tx     = state_reg.global_cfg[GCF_PATH_MSB:GCF_PATH_LSB]
                                          == JITTER_PATH_TX;
    assign global_ctrl.jitter_in_rx     = state_reg.global_cfg[GCF_PATH_MSB:GCF_PATH_LSB]
                                          == JITTER_PATH_RX;
    assign global_ctrl.soft_reset_busy  = busy;

    // ==================================================================
    // Checks
    default clocking chk_clk @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic [7:0] loss_blocked;
    logic [7:0] ais_blocked;
    logic [6:0] busy_run;

    // Changes that the mask must keep out, on bits whose flag is still clear
    assign loss_blocked = changed.loss & ~state_reg.loss_mask & ~state_reg.loss_flags;
    assign ais_blocked  = changed.alarm_indication_state & ~state_reg.ais_mask & ~state_reg.ais_flags;

    always_ff @(posedge clk) begin
        if (!resetn || !busy) begin
            busy_run <= 7'h00;
        end else begin
            busy_run <= busy_run + 7'h01;
        end
    end

    loss_flag_set_a: assert property (
        !busy && !(host_req.wr && host_req.addr == ADDR_SOFT_RESET) && |loss_evt
        |=> (state_reg.loss_flags & $past(loss_evt)) == $past(loss_evt))
        else $error("loss flag not set on masked change");
    loss_flag_clear_a: assert property (
        rd_ok && host_req.addr == ADDR_LOSS_STATE && loss_evt == 8'h00
        |=> state_reg.loss_flags == 8'h00)
        else $error("loss flag not cleared by status read");
    loss_flag_block_a: assert property (
        loss_blocked != 8'h00
        |=> (state_reg.loss_flags & $past(loss_blocked)) == 8'h00)
        else $error("masked loss change set a flag");
    fault_flag_set_a: assert property (
        !busy && !host_req.wr && |fault_evt
        |=> (state_reg.fault_flags & $past(fault_evt)) == $past(fault_evt))
        else $error("fault flag not set on masked change");
    fault_flag_clear_a: assert property (
        rd_ok && host_req.addr == ADDR_FAULT_STATE && fault_evt == 8'h00
        |=> state_reg.fault_flags == 8'h00)
        else $error("fault flag not cleared by status read");
    ais_flag_set_a: assert property (
        !busy && !host_req.wr && |ais_evt
        |=> (state_reg.ais_flags & $past(ais_evt)) == $past(ais_evt))
        else $error("ALARM_INDICATION_STATE flag not set on masked change");
    ais_flag_mask_a: assert property (
        ais_blocked != 8'h00
        |=> (state_reg.ais_flags & $past(ais_blocked)) == 8'h00)
        else $error("masked ALARM_INDICATION_STATE change set a flag");
    reset_length_a: assert property (
        $fell(busy) |-> busy_run == 7'(SRST_CYCLES_INT))
        else $error("soft reset cycle length wrong");
    reset_clears_a: assert property (
        wr_ok && host_req.addr == ADDR_SOFT_RESET
        |=> busy ##1 (state_reg.loopback == 8'h00 && state_reg.global_cfg == 7'h00))
        else $error("soft reset did not restore defaults");
    reset_holds_a: assert property (
        busy |=> state_reg.driver_hiz == RST_CHANNEL_REG && state_reg.ais_mask == RST_CHANNEL_REG
            && state_reg.monitor == RST_MONITOR)
        else $error("register changed during soft reset");
    reset_readback_a: assert property (
        rd_ok && host_req.addr == ADDR_SOFT_RESET
        |=> host_rvalid && host_rdata == RST_SOFT_RESET)
        else $error("reset location did not read all ones");
    monitor_rx_a: assert property (
        wr_ok && host_req.addr == ADDR_MONITOR && !host_req.wdata[MON_TX_BIT] && host_req.wdata[2:0] != 3'h0
        |=> global_ctrl.monitor_active && !global_ctrl.monitor_tx)
        else $error("receiver monitor code not routed");
    monitor_route_a: assert property (
        wr_ok && host_req.addr == ADDR_MONITOR
        |=> global_ctrl.monitor_active == ($past(host_req.wdata[2:0]) != 3'h0)
            && global_ctrl.monitor_tx == $past(host_req.wdata[3])
            && global_ctrl.monitor_channel == $past(host_req.wdata[2:0]))
        else $error("monitor routing does not follow written code");
    monitor_upper_a: assert property (
        rd_ok && host_req.addr == ADDR_MONITOR
        |=> host_rdata[7:4] == 4'h0)
        else $error("upper monitor bits not zero");
    loopback_write_a: assert property (
        wr_ok && host_req.addr == ADDR_LOOPBACK
        |=> channel_ctrl.loopback_en == $past(host_req.wdata))
        else $error("loopback control not updated");
    criteria_write_a: assert property (
        wr_ok && host_req.addr == ADDR_CRITERIA
        |=> channel_ctrl.criteria_etsi == $past(host_req.wdata))
        else $error("criteria control not updated");
    all_ones_a: assert property (
        state_reg.auto_ones == 8'h00 ##1 state_reg.auto_ones == 8'h00
        |=> channel_ctrl.all_ones_tx == 8'h00)
        else $error("all ones sent without enable");
    ami_select_a: assert property (
        wr_ok && host_req.addr == ADDR_GLOBAL
        |=> global_ctrl.ami_select == $past(host_req.wdata[GCF_AMI]))
        else $error("encoding select not applied");
    fifo_depth_a: assert property (
        wr_ok && host_req.addr == ADDR_GLOBAL
        |=> global_ctrl.jitter_fifo_deep == $past(host_req.wdata[GCF_FIFO_DEPTH]))
        else $error("jitter depth not applied");
    bandwidth_a: assert property (
        wr_ok && host_req.addr == ADDR_GLOBAL
        |=> global_ctrl.jitter_bw_high == $past(host_req.wdata[GCF_BANDWIDTH]))
        else $error("jitter bandwidth not applied");
    jitter_path_a: assert property (
        wr_ok && host_req.addr == ADDR_GLOBAL
        |=> global_ctrl.jitter_in_tx == ($past(host_req.wdata[1:0]) == 2'h1)
            && global_ctrl.short_protect_on == !$past(host_req.wdata[5]))
        else $error("global config not applied");
    hiz_write_a: assert property (
        wr_ok && host_req.addr == ADDR_DRIVER_HIZ
        |=> channel_ctrl.driver_hiz == $past(host_req.wdata))
        else $error("driver high impedance control not updated");
    ais_status_a: assert property (
        rd_ok && host_req.addr == ADDR_AIS_STATE
        |=> host_rdata == $past(state_reg.stable.alarm_indication_state))
        else $error("ALARM_INDICATION_STATE status readback wrong");

    soft_reset_c: cover property (wr_ok && host_req.addr == ADDR_SOFT_RESET ##1 busy);
    loss_flag_c:  cover property (|loss_evt ##1 rd_ok && host_req.addr == ADDR_LOSS_STATE);
    monitor_tx_c: cover property (global_ctrl.monitor_active && global_ctrl.monitor_tx);
    ais_flag_c:   cover property (|ais_evt);

endmodule // e1_liu_control_status_bank

// File: verification/line_front_model.sv
// Purpose: Behavioural front end that presents per-channel alarm levels to the bank
// Assumes: The bench names the wanted state; bit n of each field is channel n
// Notes:   Levels move a few ns after the bench asks, off the clock grid

`timescale 1ns/100ps

module line_front_model
    import e1_liu_bank_pkg::*;
(
    // Requested state from the bench
    input  wire line_status_type target,
    // Levels on the status pins
    output line_status_type      line_status
);
    // ==================================================================
    // Asynchronous drive
    initial line_status = '0;
    // Off-grid edges exercise the synchroniser as a real alarm would
    always @(target) line_status <= #3 target;
endmodule // line_front_model

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the E1 line interface control/status bank
// Assumes: Host strobes are one-cycle pulses; read data comes one cycle after the strobe
// Notes:   Reads queue their expected byte; a watcher compares on every host_rvalid

`timescale 1ns/100ps

module tb_top;
    import e1_liu_bank_pkg::*;
    logic             clk;
    logic             resetn;
    host_req_type     req;
    line_status_type  target;
    line_status_type  line_status;
    logic [7:0]       host_rdata;
    logic             host_rvalid;
    channel_ctrl_type channel_ctrl;
    global_ctrl_type  global_ctrl;
    logic [7:0]       exp_q[$];
    logic [2:0][7:0]  cur;
    logic [7:0]       v, m, d;
    int               n_errors, checks, cyc;
    integer           seed;
    logic [7:0]       map_a [13] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
                                     8'h12, 8'h13, 8'h14, 8'h15, 8'h11};
    logic [7:0]       st_a [3] = '{ADDR_LOSS_STATE, ADDR_FAULT_STATE, ADDR_AIS_STATE};
    logic [7:0]       mk_a [3] = '{ADDR_LOSS_MASK, ADDR_FAULT_MASK, ADDR_AIS_MASK};
    logic [7:0]       fl_a [3] = '{ADDR_LOSS_FLAGS, ADDR_FAULT_FLAGS, ADDR_AIS_FLAGS};

    e1_liu_control_status_bank dut_u (.clk(clk), .resetn(resetn), .host_req(req), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .line_status(line_status), .channel_ctrl(channel_ctrl),
        .global_ctrl(global_ctrl));
    line_front_model front_u (.target(target), .line_status(line_status));

    // ==================================================================
    // Clock, timeout and shared tasks
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge clk);
        req.wr = 1'b1; req.addr = a; req.wdata = dat;
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        req.rd = 1'b1; req.addr = a;
        exp_q.push_back(e);
        @(negedge clk);
        req.rd = 1'b0;
    endtask
    task automatic read_defaults;
        // ALARM_INDICATION_STATE status is live line state, which a soft reset does not touch
        foreach (map_a[i]) rd(map_a[i], (map_a[i] == ADDR_SOFT_RESET) ? RST_SOFT_RESET :
                              (map_a[i] == ADDR_AIS_STATE) ? cur[0] : RST_CHANNEL_REG);
    endtask

    // ==================================================================
    // Read watcher: oldest note against each answer
    always @(negedge clk) begin
        if (host_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check({7'h00, host_rvalid}, 8'h00);
            else check(host_rdata, exp_q.pop_front());
        end
    end

    // ==================================================================
    // Main sequence
    initial begin
        seed = 81; req = '0; target = '0; cur = '0; resetn = 1'b0;
        n_errors = 0; checks = 0; cyc = 0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        check({7'h00, global_ctrl.short_protect_on}, 8'h01);
        read_defaults();
        v = $random(seed); wr(ADDR_LOOPBACK, v); check(channel_ctrl.loopback_en, v); rd(ADDR_LOOPBACK, v);
        v = $random(seed); wr(ADDR_CRITERIA, v); check(channel_ctrl.criteria_etsi, v); rd(ADDR_CRITERIA, v);
        v = $random(seed); wr(ADDR_DRIVER_HIZ, v); check(channel_ctrl.driver_hiz, v); rd(ADDR_DRIVER_HIZ, v);
        // Reserved bits stay zero in every write below
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_MONITOR, 8'(c));
            check({5'h00, global_ctrl.monitor_active, global_ctrl.monitor_tx, global_ctrl.monitor_channel[0]},
                  {5'h00, 1'(c[2:0] != 3'h0), 1'(c[3]), 1'(c[0])});
            check({5'h00, global_ctrl.monitor_channel}, {5'h00, 3'(c)});
            rd(ADDR_MONITOR, 8'(c));
        end
        for (int j = 0; j < 8; j++) begin
            v = $random(seed);
            v = {1'b0, v[6:2], 2'(j)};
            wr(ADDR_GLOBAL, v);
            check({1'b0, global_ctrl.short_protect_on, global_ctrl.ami_select, global_ctrl.jitter_fifo_deep,
                   global_ctrl.jitter_bw_high, 1'b0, global_ctrl.jitter_in_tx, global_ctrl.jitter_in_rx},
                  {1'b0, ~v[5], v[4], v[3], v[2], 1'b0, v[1:0] == 2'h1, v[1:0] == 2'h3});
            rd(ADDR_GLOBAL, v);
        end
        // Flags follow masked changes; only a status read or a soft reset clears them
        for (int k = 0; k < 3; k++) begin
            for (int r = 0; r < 3; r++) begin
                m = $random(seed); d = $random(seed);
                if (r == 0) m = 8'h00;
                wr(mk_a[k], m); rd(mk_a[k], m);
                cur[2-k] = cur[2-k] ^ d; target = cur;
                repeat (8) @(negedge clk);
                rd(fl_a[k], d & m); rd(fl_a[k], d & m);
                rd(st_a[k], cur[2-k]); rd(fl_a[k], 8'h00);
            end
        end
        cur[2] = 8'h5A; target = cur;
        v = $random(seed); wr(ADDR_AUTO_ONES, v); wr(ADDR_GLOBAL, 8'h40);
        repeat (8) @(negedge clk);
        check(channel_ctrl.all_ones_tx, v & cur[2]);
        check(channel_ctrl.alarm_insert, cur[2]);
        wr(ADDR_GLOBAL, 8'h00); repeat (3) @(negedge clk);
        check(channel_ctrl.alarm_insert, 8'h00);
        // Soft reset, with a write dropped while it runs
        wr(ADDR_LOOPBACK, 8'hC3); v = $random(seed);
        wr(ADDR_SOFT_RESET, v);
        check({7'h00, global_ctrl.soft_reset_busy}, 8'h01);
        wr(ADDR_DRIVER_HIZ, 8'hFF);
        repeat (45) @(negedge clk);
        check({7'h00, global_ctrl.soft_reset_busy}, 8'h00);
        check(channel_ctrl.loopback_en, 8'h00);
        check(channel_ctrl.driver_hiz, 8'h00);
        read_defaults();
        rd(ADDR_LOOPBACK, 8'h00);
        repeat (3) @(negedge clk);
        check(8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule // tb_top
